//--- dual_wiper_register_bank.sv
// Purpose: two wiper setting registers, their stored settings, and the serial slave
// Assumes: clk far faster than the serial clock; pins pass the filtered synchroniser
// Notes:   byte 0 = prefix, four address bits, read/write; byte 1 = pointer; then data
`timescale 1ns/1ps
module dual_wiper_register_bank (
	input  wire logic                                        clk,
	input  wire logic                                        resetn,
	input  wire logic                                        serial_clock,
	input  wire logic                                        serial_data_in,
	output logic                                             serial_data_out,
	output logic                                             serial_data_oe,
	input  wire logic                                        write_protect,
	input  wire logic                                        address_select_bit_lsb,
	input  wire logic                                        address_select_bit_one,
	input  wire logic                                        address_select_bit_two,
	input  wire logic                                        address_select_bit_three,
	output wiper_bank_pkg::wiper_t [wiper_bank_pkg::NUM_POTS-1:0] wiper_setting_register,
	output wiper_bank_pkg::taps_t  [wiper_bank_pkg::NUM_POTS-1:0] tap_select
);
	import wiper_bank_pkg::*;

	// synchronised pins; floating write-protect must be pulled up on the board
	logic                  scl_s;
	logic                  sda_s;
	logic                  wp_s;
	logic [ADDR_PIN_W-1:0] addr_s;

	pin_sync #(.W(3), .INIT(3'h7)) u_sync_link (
		.clk    (clk),
		.resetn (resetn),
		.pin    ({serial_clock, serial_data_in, write_protect}),
		.level  ({scl_s, sda_s, wp_s})
	);

	pin_sync #(.W(ADDR_PIN_W), .INIT(4'h0)) u_sync_addr (
		.clk    (clk),
		.resetn (resetn),
		.pin    ({address_select_bit_three, address_select_bit_two,
		          address_select_bit_one, address_select_bit_lsb}),
		.level  (addr_s)
	);

	// edge and bus condition detection
	logic scl_q_r;
	logic sda_q_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise  = scl_s & ~scl_q_r;
	assign scl_fall  = ~scl_s & scl_q_r;
	assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;

	// register storage
	wiper_t [NUM_POTS-1:0][NUM_SLOTS-1:0] stored_setting_register;
	wiper_t [NUM_POTS-1:0]                wiper_r;
	logic                                 recall_pending_r;

	// serial link state
	link_state_t      state_r;
	logic [2:0]       bit_cnt_r;
	logic             full_r;
	logic [7:0]       shift_r;
	logic [7:0]       tx_r;
	logic [PTR_W-1:0] ptr_r;
	logic             rw_r;
	logic             nack_r;
	logic             sda_oe_r;
	logic             wr_pulse_r;
	logic [PTR_W-1:0] wr_ptr_r;
	logic [7:0]       wr_data_r;

	logic             addr_match;
	logic             data_phase;
	logic             ptr_store;
	logic             ptr_pot;
	logic [1:0]       ptr_slot;
	wiper_t           read_value;

	assign addr_match = (shift_r[7:1] == {ADDR_PREFIX, addr_s});
	// acknowledge clocks must not count as data bits, or the next byte ends one bit early
	assign data_phase = (state_r == ST_ADDR) || (state_r == ST_PTR)
		|| (state_r == ST_WDATA) || (state_r == ST_RDATA);
	assign ptr_store  = ptr_r[PTR_STORE];
	assign ptr_pot    = ptr_r[PTR_POT];
	assign ptr_slot   = ptr_r[PTR_SLOT_HI:PTR_SLOT_LO];
	assign read_value = ptr_store ? stored_setting_register[ptr_pot][ptr_slot] : wiper_r[ptr_pot];

	// bit shifter: data is sampled on the serial clock rising edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_r   <= 8'h00;
			bit_cnt_r <= 3'h0;
			full_r    <= 1'b0;
		end else if (bus_start || bus_stop) begin
			bit_cnt_r <= 3'h0;
			full_r    <= 1'b0;
		end else if (scl_rise && data_phase) begin
			shift_r   <= {shift_r[6:0], sda_s};
			bit_cnt_r <= bit_cnt_r + 3'h1;
			full_r    <= (bit_cnt_r == LAST_BIT);
		end else if (scl_fall && full_r) begin
			full_r <= 1'b0;
		end
	end

	// master acknowledge after a read byte; high means stop sending
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nack_r <= 1'b1;
		end else if (scl_rise && state_r == ST_RDATA_ACK) begin
			nack_r <= sda_s;
		end
	end

	// transfer sequencer; the data line only moves on a falling serial clock, a start or a stop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= ST_IDLE;
			sda_oe_r   <= 1'b0;
			rw_r       <= 1'b0;
			ptr_r      <= '0;
			tx_r       <= 8'h00;
			wr_pulse_r <= 1'b0;
			wr_ptr_r   <= '0;
			wr_data_r  <= 8'h00;
		end else begin
			wr_pulse_r <= 1'b0;
			if (bus_start) begin
				state_r  <= ST_ADDR;
				sda_oe_r <= 1'b0;
			end else if (bus_stop) begin
				state_r  <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (scl_fall) begin
				case (state_r)
				ST_ADDR: begin
					if (full_r) begin
						if (addr_match) begin
							state_r  <= ST_ADDR_ACK;
							sda_oe_r <= 1'b1;
							rw_r     <= shift_r[RW_BIT];
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (rw_r) begin
						state_r  <= ST_RDATA;
						tx_r     <= read_value;
						sda_oe_r <= ~read_value[7];
					end else begin
						state_r  <= ST_PTR;
						sda_oe_r <= 1'b0;
					end
				end
				ST_PTR: begin
					if (full_r) begin
						ptr_r    <= shift_r[PTR_W-1:0];
						state_r  <= ST_PTR_ACK;
						sda_oe_r <= 1'b1;
					end
				end
				ST_PTR_ACK: begin
					state_r  <= ST_WDATA;
					sda_oe_r <= 1'b0;
				end
				ST_WDATA: begin
					if (full_r) begin
						state_r <= ST_WDATA_ACK;
						// a refused stored write is simply not acknowledged
						if (!ptr_store || wp_s) begin
							wr_pulse_r <= 1'b1;
							wr_ptr_r   <= ptr_r;
							wr_data_r  <= shift_r;
							sda_oe_r   <= 1'b1;
						end
					end
				end
				ST_WDATA_ACK: begin
					state_r  <= ST_WDATA;
					sda_oe_r <= 1'b0;
				end
				ST_RDATA: begin
					if (full_r) begin
						state_r  <= ST_RDATA_ACK;
						sda_oe_r <= 1'b0;
					end else begin
						sda_oe_r <= ~tx_r[LAST_BIT - bit_cnt_r];
					end
				end
				ST_RDATA_ACK: begin
					if (nack_r) begin
						state_r <= ST_IDLE;
					end else begin
						state_r  <= ST_RDATA;
						tx_r     <= read_value;
						sda_oe_r <= ~read_value[7];
					end
				end
				ST_IDLE: begin
					sda_oe_r <= 1'b0;
				end
				default: begin
					state_r  <= ST_IDLE;
					sda_oe_r <= 1'b0;
				end
				endcase
			end
		end
	end

	assign serial_data_out = 1'b0;
	assign serial_data_oe  = sda_oe_r;

	// stored settings; held in flops, so every reset reloads them with STORED_RESET
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stored_setting_register <= {(NUM_POTS*NUM_SLOTS){STORED_RESET}};
		end else if (wr_pulse_r && wr_ptr_r[PTR_STORE] && wp_s) begin
			stored_setting_register[wr_ptr_r[PTR_POT]][wr_ptr_r[PTR_SLOT_HI:PTR_SLOT_LO]] <= wr_data_r;
		end
	end

	// wiper setting registers with one-time recall after reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wiper_r          <= {NUM_POTS{WIPER_RESET}};
			recall_pending_r <= 1'b1;
		end else if (recall_pending_r) begin
			recall_pending_r <= 1'b0;
			for (int p = 0; p < NUM_POTS; p++) begin
				wiper_r[p] <= stored_setting_register[p][0];
			end
		end else if (wr_pulse_r && !wr_ptr_r[PTR_STORE]) begin
			wiper_r[wr_ptr_r[PTR_POT]] <= wr_data_r;
		end
	end

	assign wiper_setting_register = wiper_r;

	for (genvar p = 0; p < NUM_POTS; p++) begin : g_pot
		tap_if tif ();
		assign tif.wiper = wiper_r[p];
		tap_decoder u_dec (
			.clk    (clk),
			.resetn (resetn),
			.t      (tif)
		);
		assign tap_select[p] = tif.tap;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_recall;
		recall_pending_r |=> (wiper_r[0] == $past(stored_setting_register[0][0]))
			&& (wiper_r[1] == $past(stored_setting_register[1][0]));
	endproperty
	a_recall: assert property (p_recall) else $error("power-up recall did not load wiper");

	property p_wiper_write;
		(wr_pulse_r && !wr_ptr_r[PTR_STORE] && !recall_pending_r)
			|=> wiper_r[$past(wr_ptr_r[PTR_POT])] == $past(wr_data_r);
	endproperty
	a_wiper_write: assert property (p_wiper_write) else $error("wiper write not applied");

	property p_store_write;
		(wr_pulse_r && wr_ptr_r[PTR_STORE] && wp_s)
			|=> stored_setting_register[$past(wr_ptr_r[PTR_POT])][$past(wr_ptr_r[1:0])] == $past(wr_data_r);
	endproperty
	a_store_write: assert property (p_store_write) else $error("stored write not applied");

	property p_wp_block;
		!wp_s |=> $stable(stored_setting_register);
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("stored setting changed while protected");

	property p_open_drain;
		serial_data_oe |-> (serial_data_out == 1'b0);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("data line driven high");

	property p_addr_mismatch;
		(scl_fall && state_r == ST_ADDR && full_r && !addr_match && !bus_start && !bus_stop)
			|=> ((state_r == ST_IDLE) && !sda_oe_r) [*2];
	endproperty
	a_addr_mismatch: assert property (p_addr_mismatch) else $error("answered a foreign address");

	property p_sda_timing;
		$changed(sda_oe_r) |-> $past(scl_fall) || $past(bus_start) || $past(bus_stop);
	endproperty
	a_sda_timing: assert property (p_sda_timing) else $error("data line moved off serial clock");

	property p_write_source;
		$changed(wiper_r) && !$past(recall_pending_r) |-> $past(wr_pulse_r);
	endproperty
	a_write_source: assert property (p_write_source) else $error("wiper changed without serial write");
endmodule : dual_wiper_register_bank

//--- dual_wiper_register_bank_test.sv
// Purpose: self-checking bench of the dual wiper register bank
// Assumes: stored settings reload 8'h80 on reset; pointer {store, pot, slot}
// Notes:   address pins move only between frames, then settle 10 clocks
`timescale 1ns/1ps
module dual_wiper_register_bank_test;
	import wiper_bank_pkg::*;
	logic                  clk;
	logic                  resetn;
	logic                  write_protect;
	logic [3:0]            pins;
	logic                  scl;
	logic                  pull_low;
	wire                   sda;
	logic                  sd_out;
	logic                  sd_oe;
	wiper_t [NUM_POTS-1:0] wiper;
	taps_t  [NUM_POTS-1:0] taps;
	int                    n_errors;
	int                    n_checks;
	int                    cycles;

	assign sda = ~(sd_oe | pull_low);

	dual_wiper_register_bank DUT (
		.clk(clk), .resetn(resetn), .serial_clock(scl), .serial_data_in(sda),
		.serial_data_out(sd_out), .serial_data_oe(sd_oe), .write_protect(write_protect),
		.address_select_bit_lsb(pins[0]), .address_select_bit_one(pins[1]),
		.address_select_bit_two(pins[2]), .address_select_bit_three(pins[3]),
		.wiper_setting_register(wiper), .tap_select(taps)
	);

	twowire_master_model master (.scl(scl), .pull_low(pull_low), .sda(sda));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_errors++;
			$display("MISMATCH at %0t: timeout", $time);
			give_verdict();
		end
	end

	task automatic cmp_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: bit got %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic cmp_byte(input wiper_t got, input wiper_t exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: byte got %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte

	task automatic cmp_taps(input taps_t got, input wiper_t v);
		taps_t e;
		e = '0;
		e[v] = 1'b1;
		n_checks++;
		if (got !== e) begin
			n_errors++;
			$display("MISMATCH at %0t: tap select wrong for wiper %h", $time, v);
		end
	endtask : cmp_taps

	task automatic check_pot(input int p, input wiper_t v);
		cmp_byte(wiper[p], v);
		cmp_taps(taps[p], v);
	endtask : check_pot

	task automatic write_reg(input logic [3:0] adr, input logic [3:0] ptr, input wiper_t d, output logic ack);
		logic a;
		master.start();
		master.send({ADDR_PREFIX, adr, 1'b0}, a);
		master.send({4'h0, ptr}, a);
		master.send(d, ack);
		master.stop();
		repeat (4) @(posedge clk);
	endtask : write_reg

	task automatic read_reg(input logic [3:0] ptr, output wiper_t d);
		logic a;
		master.start();
		master.send({ADDR_PREFIX, pins, 1'b0}, a);
		master.send({4'h0, ptr}, a);
		master.start();
		master.send({ADDR_PREFIX, pins, 1'b1}, a);
		master.recv(1'b0, d);
		master.stop();
	endtask : read_reg

	task automatic t_recall();
		cmp_bit(sd_oe, 1'b0);
		cmp_bit(sd_out, 1'b0);
		check_pot(0, STORED_RESET);
		check_pot(1, STORED_RESET);
	endtask : t_recall

	task automatic t_address();
		logic a;
		for (int k = 0; k < 16; k++) begin
			pins <= 4'(k);
			repeat (10) @(posedge clk);
			master.start();
			master.send({ADDR_PREFIX, 4'(k), 1'b0}, a);
			cmp_bit(a, 1'b1);
			master.start();
			master.send({ADDR_PREFIX, 4'(k) ^ 4'h1, 1'b0}, a);
			cmp_bit(a, 1'b0);
			master.stop();
		end
		pins <= 4'ha;
		repeat (10) @(posedge clk);
	endtask : t_address

	task automatic t_wiper();
		wiper_t vals[3] = '{8'h00, 8'hff, 8'h5a};
		wiper_t d;
		logic a;
		foreach (vals[i])
			for (int p = 0; p < 2; p++) begin
				write_reg(pins, {1'b0, p[0], 2'h0}, vals[i] ^ 8'(p), a);
				cmp_bit(a, 1'b1);
				check_pot(p, vals[i] ^ 8'(p));
				read_reg({1'b0, p[0], 2'h0}, d);
				cmp_byte(d, vals[i] ^ 8'(p));
			end
	endtask : t_wiper

	// first pass reads reset values, second writes, third reads back
	task automatic t_stored();
		wiper_t d;
		logic a;
		for (int pass = 0; pass < 3; pass++)
			for (int s = 0; s < 8; s++) begin
				if (pass == 1) begin
					write_reg(pins, {1'b1, 3'(s)}, 8'h30 + 8'(s), a);
					cmp_bit(a, 1'b1);
				end else begin
					read_reg({1'b1, 3'(s)}, d);
					cmp_byte(d, pass == 0 ? STORED_RESET : 8'h30 + 8'(s));
				end
			end
		check_pot(0, 8'h5a);
		check_pot(1, 8'h5b);
	endtask : t_stored

	task automatic t_protect();
		wiper_t d;
		logic a;
		write_protect <= 1'b0;
		repeat (10) @(posedge clk);
		write_reg(pins, 4'he, 8'hc3, a);
		cmp_bit(a, 1'b0);
		read_reg(4'he, d);
		cmp_byte(d, 8'h36);
		write_reg(pins, 4'h4, 8'h37, a);
		cmp_bit(a, 1'b1);
		check_pot(1, 8'h37);
		write_protect <= 1'b1;
		repeat (10) @(posedge clk);
	endtask : t_protect

	task automatic t_foreign();
		logic a;
		write_reg(pins ^ 4'h8, 4'h0, 8'h11, a);
		cmp_bit(a, 1'b0);
		check_pot(0, 8'h5a);
	endtask : t_foreign

	// two-byte read: master acks the first byte, no pointer is sent and the last one is read twice
	task automatic t_burst();
		wiper_t d;
		logic a;
		master.start();
		master.send({ADDR_PREFIX, pins, 1'b1}, a);
		cmp_bit(a, 1'b1);
		master.recv(1'b1, d);
		cmp_byte(d, 8'h37);
		master.recv(1'b0, d);
		cmp_byte(d, 8'h37);
		master.stop();
		repeat (4) @(posedge clk);
	endtask : t_burst

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial begin
		resetn = 1'b0;
		write_protect = 1'b1;
		pins = 4'ha;
		n_errors = 0;
		n_checks = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (12) @(posedge clk);
		t_recall();
		t_address();
		t_wiper();
		t_stored();
		t_protect();
		t_foreign();
		t_burst();
		give_verdict();
	end
endmodule : dual_wiper_register_bank_test

//--- pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for slow pins
// Assumes: inputs are asynchronous to clk
// Notes:   output moves only once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	if (W < 1) begin : g_bad_width
		$error("pin_sync: width must be at least one");
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		logic s1_r;
		logic s2_r;
		logic s3_r;
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				s1_r     <= INIT[i];
				s2_r     <= INIT[i];
				s3_r     <= INIT[i];
				level[i] <= INIT[i];
			end else begin
				s1_r <= pin[i];
				s2_r <= s1_r;
				s3_r <= s2_r;
				if (s2_r == s3_r) begin
					level[i] <= s3_r;
				end
			end
		end
	end
endmodule : pin_sync

//--- tap_decoder.sv
// Purpose: turns one wiper value into a one-hot tap select
// Assumes: value zero is the low end terminal tap
// Notes:   registered so the tap switch never sees decode glitches
`timescale 1ns/1ps
module tap_decoder (
	input  wire logic clk,
	input  wire logic resetn,
	tap_if.dec        t
);
	import wiper_bank_pkg::*;

	localparam taps_t ONE = taps_t'(1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t.tap <= ONE << WIPER_RESET;
		end else begin
			t.tap <= ONE << t.wiper;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_tap_onehot;
		$onehot(t.tap);
	endproperty
	a_tap_onehot: assert property (p_tap_onehot) else $error("tap select not one-hot");

	property p_tap_ends;
		(t.wiper == 8'h00) |=> t.tap[0];
	endproperty
	a_tap_ends: assert property (p_tap_ends) else $error("zero wiper missed low end tap");

	property p_tap_map;
		##1 t.tap[$past(t.wiper)];
	endproperty
	a_tap_map: assert property (p_tap_map) else $error("tap does not follow wiper value");
endmodule : tap_decoder

//--- tap_if.sv
// Purpose: carries one wiper value to its tap decoder and the tap select back
// Assumes: one instance per potentiometer
// Notes:   none
`timescale 1ns/1ps
interface tap_if;
	import wiper_bank_pkg::*;
	wiper_t wiper;
	taps_t  tap;
	modport core (output wiper, input tap);
	modport dec  (input wiper, output tap);
endinterface : tap_if

//--- twowire_master_model.sv
// Purpose: two-wire bus master that owns the serial clock
// Assumes: data line has a pull-up; pull_low high drags it low
// Notes:   clock stands high between frames; 48 ns bit cell, phase offset from clk
`timescale 1ns/1ps
module twowire_master_model (
	output logic      scl,
	output logic      pull_low,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end

	// data moves 8 ns after the fall so it never races the clock filter
	task automatic put_bit(input logic b, output logic r);
		#8 pull_low = ~b;
		#16 scl = 1'b1;
		#20 r = sda;
		#4 scl = 1'b0;
	endtask : put_bit

	task automatic start();
		#1.5;
		if (!scl) begin
			#8 pull_low = 1'b0;
			#16 scl = 1'b1;
			#24;
		end
		pull_low = 1'b1;
		#24 scl = 1'b0;
	endtask : start

	task automatic stop();
		#8 pull_low = 1'b1;
		#16 scl = 1'b1;
		#24 pull_low = 1'b0;
		#24;
	endtask : stop

	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], r);
		put_bit(1'b1, r);
		ack = ~r;
	endtask : send

	task automatic recv(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, r);
			d[i] = r;
		end
		put_bit(~more, r);
	endtask : recv
endmodule : twowire_master_model

//--- wiper_bank_pkg.sv
// Purpose: shared constants and types of the dual wiper register bank
// Assumes: one system clock, serial link sampled as ordinary pins
// Notes:   stored settings stand in flops, so they reload on every reset
package wiper_bank_pkg;
	localparam int NUM_POTS   = 2;
	localparam int NUM_SLOTS  = 4;
	localparam int WIPER_W    = 8;
	localparam int NUM_TAPS   = 256;
	localparam int SYNC_DEPTH = 3;

	typedef logic [WIPER_W-1:0]  wiper_t;
	typedef logic [NUM_TAPS-1:0] taps_t;

	// serial byte layout
	localparam int ADDR_PIN_W   = 4;
	localparam int ADDR_PFX_W   = 3;
	localparam int RW_BIT       = 0;
	localparam int PTR_W        = 4;
	localparam int PTR_STORE    = 3;
	localparam int PTR_POT      = 2;
	localparam int PTR_SLOT_HI  = 1;
	localparam int PTR_SLOT_LO  = 0;

	// arbitrary value, not taken from any part
	localparam logic [ADDR_PFX_W-1:0] ADDR_PREFIX = 3'h5;
	localparam wiper_t                WIPER_RESET  = 8'h00;
	localparam wiper_t                STORED_RESET = 8'h80;
	localparam logic [2:0]            LAST_BIT     = 3'h7;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h3,
		ST_PTR       = 4'h2,
		ST_PTR_ACK   = 4'h6,
		ST_WDATA     = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA     = 4'h4,
		ST_RDATA_ACK = 4'hc
	} link_state_t;
endpackage : wiper_bank_pkg
